/* lmw_regs.vh */
// Register offsets, function codes, value codes and reset values of the load mode bank.
`ifndef LMW_REGS_VH
`define LMW_REGS_VH
`define LMW_REGULATION_SELECT_WR 16'h6030
`define LMW_REGULATION_SELECT_RD 16'h6040
`define LMW_WAVEFORM_SELECT_WR   16'h7010
`define LMW_WAVEFORM_SELECT_RD   16'h7020
`define LMW_SINE_AMPLITUDE_WR    16'h7030
`define LMW_SINE_AMPLITUDE_RD    16'h7040
`define LMW_SINE_OFFSET_WR       16'h7050
`define LMW_SINE_OFFSET_RD       16'h7060
`define LMW_SINE_PERIOD_WR       16'h7070
`define LMW_SINE_PERIOD_RD       16'h7080
`define LMW_SQUARE_LOW_WR        16'h7090
`define LMW_SQUARE_LOW_RD        16'h70A0
`define LMW_SQUARE_HIGH_WR       16'h70B0
`define LMW_SQUARE_HIGH_RD       16'h70C0
`define LMW_FC_READ_HOLDING      8'h03
`define LMW_FC_WRITE_SINGLE      8'h06
`define LMW_FC_WRITE_MULTIPLE    8'h10
`define LMW_EXC_NONE             8'h00
`define LMW_EXC_FUNCTION         8'h01
`define LMW_EXC_ADDRESS          8'h02
`define LMW_EXC_VALUE            8'h03
`define LMW_COUNT_INTEGER        16'h0001
`define LMW_COUNT_FLOAT          16'h0002
`define LMW_MODE_FIRST           16'h0001
`define LMW_MODE_COUNT           6
`define LMW_WAVE_FIRST           16'h0000
`define LMW_WAVE_COUNT           4
`define LMW_WAVE_SINE_BIT        0
`define LMW_WAVE_SQUARE_BIT      1
`define LMW_SOURCE_FUNC_GEN      16'h0001
`define LMW_PERIOD_MIN_MS        32'h40000000
`define LMW_PERIOD_MAX_MS        32'h477DE800
`define LMW_LEVEL_MIN            32'h00000000
`define LMW_LEVEL_MAX            32'h7F7FFFFF
`define LMW_RST_REGULATION       16'h0001
`define LMW_RST_WAVEFORM         16'h0000
`define LMW_RST_LEVEL            32'h00000000
`define LMW_RST_PERIOD           32'h40000000
`endif

/* lmw_float_clamp.v */
// Clamps a single-precision value into a closed range; negative values go to the low end.
`timescale 1ns/10ps
module lmw_float_clamp #(
   parameter [31:0] LO = 32'h00000000,
   parameter [31:0] HI = 32'h7F7FFFFF
) (
   input  wire [31:0] value_i,
   output reg  [31:0] value_o,
   output reg         clamped_o
);
   // Positive floats order like unsigned integers, so plain compares suffice.
   always @* begin
      value_o   = value_i;
      clamped_o = 1'b0;
      if (value_i[31] || (value_i < LO)) begin
         value_o   = LO;
         clamped_o = 1'b1;
      end else if (value_i > HI) begin
         value_o   = HI;
         clamped_o = 1'b1;
      end
   end
endmodule // lmw_float_clamp

/* lmw_decode_onehot.v */
// Decodes a 16-bit selector code into a one-hot vector with a validity flag.
`timescale 1ns/10ps
module lmw_decode_onehot #(
   parameter        WIDTH = 4,
   parameter [15:0] BASE  = 16'h0000
) (
   input  wire [15:0]      code_i,
   output wire [WIDTH-1:0] onehot_o,
   output wire             valid_o
);
   genvar g;
   generate
      for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
         localparam [31:0] CODE = BASE + g;
         assign onehot_o[g] = ({16'h0000, code_i} == CODE);
      end
   endgenerate
   assign valid_o = |onehot_o;
endmodule // lmw_decode_onehot

/* lmw_load_mode_waveform_regs.v */
// Regulation mode, waveform selector and waveform parameter register bank.
`timescale 1ns/10ps
`include "lmw_regs.vh"
module lmw_load_mode_waveform_regs #(
   parameter [31:0] LEVEL_MAX = `LMW_LEVEL_MAX
) (
   input  wire        sys_clk_i,
   input  wire        rst_b_i,
   input  wire        ce_i,
   input  wire        req_valid_i,
   input  wire [7:0]  req_func_i,
   input  wire [15:0] req_addr_i,
   input  wire [15:0] req_count_i,
   input  wire [31:0] req_data_i,
   output reg         req_ready_o,
   output reg         rsp_valid_o,
   output reg  [15:0] rsp_word_o,
   output reg         rsp_last_o,
   output reg  [7:0]  rsp_exc_o,
   input  wire [15:0] set_point_source_i,
   output reg  [15:0] regulation_select_o,
   output reg  [5:0]  mode_onehot_o,
   output reg  [3:0]  waveform_onehot_o,
   output reg         fg_drives_setpoint_o,
   output reg         sine_active_o,
   output reg         square_active_o,
   output reg  [31:0] sine_amplitude_o,
   output reg  [31:0] sine_offset_o,
   output reg  [31:0] sine_period_o,
   output reg  [31:0] square_low_level_o,
   output reg  [31:0] square_high_level_o
);
   localparam ST_IDLE = 1'b0;
   localparam ST_LOW  = 1'b1;

   reg         state;
   reg  [15:0] regulation_select;
   reg  [15:0] waveform_select;
   reg  [31:0] sine_amplitude;
   reg  [31:0] sine_offset;
   reg  [31:0] sine_period;
   reg  [31:0] square_low_level;
   reg  [31:0] square_high_level;
   reg  [15:0] low_word;

   reg         next_state;
   reg         next_ready;
   reg         next_rsp_valid;
   reg  [15:0] next_rsp_word;
   reg         next_rsp_last;
   reg  [7:0]  next_rsp_exc;
   reg  [15:0] next_low_word;
   reg  [2:0]  wr_sel;
   reg         wr_single;
   reg         wr_float;
   reg  [31:0] rd_value;
   reg         rd_float;
   reg         rd_hit;

   wire        take;
   wire [31:0] level_value;
   wire [31:0] period_value;
   wire [5:0]  mode_dec;
   wire        mode_ok;
   wire [3:0]  wave_dec;
   wire        wave_ok;
   wire [3:0]  wave_live;
   wire        fg_source;

   assign take = ce_i && req_valid_i && req_ready_o && (state == ST_IDLE);

   // Negative levels are raised to zero, large ones limited to the maximum.
   lmw_float_clamp #(
      .LO (`LMW_LEVEL_MIN),
      .HI (LEVEL_MAX)
   ) u_level_clamp (
      .value_i   (req_data_i),
      .value_o   (level_value),
      .clamped_o ()
   );

   lmw_float_clamp #(
      .LO (`LMW_PERIOD_MIN_MS),
      .HI (`LMW_PERIOD_MAX_MS)
   ) u_period_clamp (
      .value_i   (req_data_i),
      .value_o   (period_value),
      .clamped_o ()
   );

   lmw_decode_onehot #(
      .WIDTH (`LMW_MODE_COUNT),
      .BASE  (`LMW_MODE_FIRST)
   ) u_mode_check (
      .code_i   (req_data_i[15:0]),
      .onehot_o (),
      .valid_o  (mode_ok)
   );

   lmw_decode_onehot #(
      .WIDTH (`LMW_MODE_COUNT),
      .BASE  (`LMW_MODE_FIRST)
   ) u_mode_dec (
      .code_i   (regulation_select),
      .onehot_o (mode_dec),
      .valid_o  ()
   );

   lmw_decode_onehot #(
      .WIDTH (`LMW_WAVE_COUNT),
      .BASE  (`LMW_WAVE_FIRST)
   ) u_wave_check (
      .code_i   (req_data_i[15:0]),
      .onehot_o (),
      .valid_o  (wave_ok)
   );

   lmw_decode_onehot #(
      .WIDTH (`LMW_WAVE_COUNT),
      .BASE  (`LMW_WAVE_FIRST)
   ) u_wave_dec (
      .code_i   (waveform_select),
      .onehot_o (wave_dec),
      .valid_o  ()
   );

   assign fg_source = (set_point_source_i == `LMW_SOURCE_FUNC_GEN);
   assign wave_live = wave_dec & {4{fg_source}};

   // Maps a write address to a target; zero means no writable register there.
   always @* begin
      wr_sel    = 3'h0;
      wr_single = 1'b0;
      wr_float  = 1'b0;
      case (req_addr_i)
         `LMW_REGULATION_SELECT_WR: begin
            wr_sel    = 3'h1;
            wr_single = 1'b1;
         end
         `LMW_WAVEFORM_SELECT_WR: begin
            wr_sel    = 3'h2;
            wr_single = 1'b1;
         end
         `LMW_SINE_AMPLITUDE_WR: begin
            wr_sel   = 3'h3;
            wr_float = 1'b1;
         end
         `LMW_SINE_OFFSET_WR: begin
            wr_sel   = 3'h4;
            wr_float = 1'b1;
         end
         `LMW_SINE_PERIOD_WR: begin
            wr_sel   = 3'h5;
            wr_float = 1'b1;
         end
         `LMW_SQUARE_LOW_WR: begin
            wr_sel   = 3'h6;
            wr_float = 1'b1;
         end
         `LMW_SQUARE_HIGH_WR: begin
            wr_sel   = 3'h7;
            wr_float = 1'b1;
         end
         default: begin
            wr_sel = 3'h0;
         end
      endcase
   end

   // Query addresses return the stored value of the paired write address.
   always @* begin
      rd_value = 32'h00000000;
      rd_float = 1'b0;
      rd_hit   = 1'b1;
      case (req_addr_i)
         `LMW_REGULATION_SELECT_RD: rd_value = {16'h0000, regulation_select};
         `LMW_WAVEFORM_SELECT_RD:   rd_value = {16'h0000, waveform_select};
         `LMW_SINE_AMPLITUDE_RD: begin
            rd_value = sine_amplitude;
            rd_float = 1'b1;
         end
         `LMW_SINE_OFFSET_RD: begin
            rd_value = sine_offset;
            rd_float = 1'b1;
         end
         `LMW_SINE_PERIOD_RD: begin
            rd_value = sine_period;
            rd_float = 1'b1;
         end
         `LMW_SQUARE_LOW_RD: begin
            rd_value = square_low_level;
            rd_float = 1'b1;
         end
         `LMW_SQUARE_HIGH_RD: begin
            rd_value = square_high_level;
            rd_float = 1'b1;
         end
         default: rd_hit = 1'b0;
      endcase
   end

   // Request decode and answer sequencing.
   always @* begin
      next_state     = state;
      next_ready     = req_ready_o;
      next_rsp_valid = 1'b0;
      next_rsp_word  = rsp_word_o;
      next_rsp_last  = rsp_last_o;
      next_rsp_exc   = rsp_exc_o;
      next_low_word  = low_word;
      case (state)
         ST_IDLE: begin
            next_ready = 1'b1;
            if (take) begin
               next_rsp_valid = 1'b1;
               next_rsp_last  = 1'b1;
               next_rsp_exc   = `LMW_EXC_NONE;
               next_rsp_word  = 16'h0000;
               case (req_func_i)
                  `LMW_FC_WRITE_SINGLE: begin
                     if (!wr_single) begin
                        next_rsp_exc = `LMW_EXC_ADDRESS;
                     end else if ((wr_sel == 3'h1) ? !mode_ok : !wave_ok) begin
                        next_rsp_exc = `LMW_EXC_VALUE;
                     end else begin
                        next_rsp_word = req_data_i[15:0];
                     end
                  end
                  `LMW_FC_WRITE_MULTIPLE: begin
                     if (!wr_float) begin
                        next_rsp_exc = `LMW_EXC_ADDRESS;
                     end else if (req_count_i != `LMW_COUNT_FLOAT) begin
                        next_rsp_exc = `LMW_EXC_VALUE;
                     end else begin
                        next_rsp_word = req_addr_i;
                     end
                  end
                  `LMW_FC_READ_HOLDING: begin
                     if (!rd_hit) begin
                        next_rsp_exc = `LMW_EXC_ADDRESS;
                     end else if (rd_float) begin
                        if (req_count_i != `LMW_COUNT_FLOAT) begin
                           next_rsp_exc = `LMW_EXC_VALUE;
                        end else begin
                           next_rsp_word = rd_value[31:16];
                           next_rsp_last = 1'b0;
                           next_low_word = rd_value[15:0];
                           next_ready    = 1'b0;
                           next_state    = ST_LOW;
                        end
                     end else if (req_count_i != `LMW_COUNT_INTEGER) begin
                        next_rsp_exc = `LMW_EXC_VALUE;
                     end else begin
                        next_rsp_word = rd_value[15:0];
                     end
                  end
                  default: next_rsp_exc = `LMW_EXC_FUNCTION;
               endcase
            end
         end
         ST_LOW: begin
            next_rsp_valid = 1'b1;
            next_rsp_word  = low_word;
            next_rsp_last  = 1'b1;
            next_rsp_exc   = `LMW_EXC_NONE;
            next_ready     = 1'b1;
            next_state     = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
            next_ready = 1'b0;
         end
      endcase
   end

   always @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state       <= ST_IDLE;
         req_ready_o <= 1'b0;
         rsp_valid_o <= 1'b0;
         rsp_word_o  <= 16'h0000;
         rsp_last_o  <= 1'b0;
         rsp_exc_o   <= `LMW_EXC_NONE;
         low_word    <= 16'h0000;
      end else if (ce_i) begin
         state       <= next_state;
         req_ready_o <= next_ready;
         rsp_valid_o <= next_rsp_valid;
         rsp_word_o  <= next_rsp_word;
         rsp_last_o  <= next_rsp_last;
         rsp_exc_o   <= next_rsp_exc;
         low_word    <= next_low_word;
      end
   end

   // Stored parameters change only on an accepted, well-formed write.
   always @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         regulation_select <= `LMW_RST_REGULATION;
         waveform_select   <= `LMW_RST_WAVEFORM;
         sine_amplitude    <= `LMW_RST_LEVEL;
         sine_offset       <= `LMW_RST_LEVEL;
         sine_period       <= `LMW_RST_PERIOD;
         square_low_level  <= `LMW_RST_LEVEL;
         square_high_level <= `LMW_RST_LEVEL;
      end else if (take) begin
         if (req_func_i == `LMW_FC_WRITE_SINGLE) begin
            if ((wr_sel == 3'h1) && mode_ok) begin
               regulation_select <= req_data_i[15:0];
            end
            if ((wr_sel == 3'h2) && wave_ok) begin
               waveform_select <= req_data_i[15:0];
            end
         end
         if ((req_func_i == `LMW_FC_WRITE_MULTIPLE) && (req_count_i == `LMW_COUNT_FLOAT)) begin
            case (wr_sel)
               3'h3:    sine_amplitude    <= level_value;
               3'h4:    sine_offset       <= level_value;
               3'h5:    sine_period       <= period_value;
               3'h6:    square_low_level  <= level_value;
               3'h7:    square_high_level <= level_value;
               default: sine_period       <= sine_period;
            endcase
         end
      end
   end

   // Decoded selections and gated parameters for the generator and regulator.
   always @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         regulation_select_o  <= `LMW_RST_REGULATION;
         mode_onehot_o        <= 6'h00;
         waveform_onehot_o    <= 4'h0;
         fg_drives_setpoint_o <= 1'b0;
         sine_active_o        <= 1'b0;
         square_active_o      <= 1'b0;
         sine_amplitude_o     <= 32'h00000000;
         sine_offset_o        <= 32'h00000000;
         sine_period_o        <= 32'h00000000;
         square_low_level_o   <= 32'h00000000;
         square_high_level_o  <= 32'h00000000;
      end else if (ce_i) begin
         regulation_select_o  <= regulation_select;
         mode_onehot_o        <= mode_dec;
         waveform_onehot_o    <= wave_dec;
         fg_drives_setpoint_o <= fg_source;
         sine_active_o        <= wave_live[`LMW_WAVE_SINE_BIT];
         square_active_o      <= wave_live[`LMW_WAVE_SQUARE_BIT];
         if (wave_live[`LMW_WAVE_SINE_BIT]) begin
            sine_amplitude_o <= sine_amplitude;
            sine_offset_o    <= sine_offset;
            sine_period_o    <= sine_period;
         end else begin
            sine_amplitude_o <= 32'h00000000;
            sine_offset_o    <= 32'h00000000;
            sine_period_o    <= 32'h00000000;
         end
         if (wave_live[`LMW_WAVE_SQUARE_BIT]) begin
            square_low_level_o  <= square_low_level;
            square_high_level_o <= square_high_level;
         end else begin
            square_low_level_o  <= 32'h00000000;
            square_high_level_o <= 32'h00000000;
         end
      end
   end
endmodule // lmw_load_mode_waveform_regs

/* lmw_load_mode_waveform_regs_properties.sv */
// Concurrent checks of the load mode and waveform register bank.
`timescale 1ns/10ps
module lmw_regs_checker #(
   parameter [31:0] LEVEL_MAX = 32'h7F7FFFFF
) (
   input wire        sys_clk_i,
   input wire        rst_b_i,
   input wire        ce_i,
   input wire        req_valid_i,
   input wire [7:0]  req_func_i,
   input wire [15:0] req_addr_i,
   input wire [15:0] req_count_i,
   input wire [31:0] req_data_i,
   input wire        req_ready_o,
   input wire        rsp_valid_o,
   input wire [15:0] rsp_word_o,
   input wire        rsp_last_o,
   input wire [7:0]  rsp_exc_o,
   input wire [15:0] set_point_source_i,
   input wire [15:0] regulation_select_o,
   input wire [5:0]  mode_onehot_o,
   input wire [3:0]  waveform_onehot_o,
   input wire        fg_drives_setpoint_o,
   input wire        sine_active_o,
   input wire        square_active_o,
   input wire [31:0] sine_amplitude_o,
   input wire [31:0] sine_offset_o,
   input wire [31:0] sine_period_o,
   input wire [31:0] square_low_level_o,
   input wire [31:0] square_high_level_o
);
   wire        tk = ce_i && req_valid_i && req_ready_o;
   wire        ws = tk && req_func_i == 8'h06;
   wire        wm = ws && req_addr_i == 16'h6030;
   wire [15:0] dv = req_data_i[15:0];
   wire        fq = req_func_i == 8'h03 && req_count_i == 16'h0002 && (req_addr_i == 16'h7040
                    || req_addr_i == 16'h7060 || req_addr_i == 16'h7080
                    || req_addr_i == 16'h70A0 || req_addr_i == 16'h70C0);
   wire        bf = req_func_i != 8'h03 && req_func_i != 8'h06 && req_func_i != 8'h10;
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i || !ce_i);
   sequence s_hi; rsp_valid_o && !rsp_last_o && !req_ready_o; endsequence
   sequence s_lo; rsp_valid_o && rsp_last_o && rsp_exc_o == 8'h00; endsequence
   sequence s_echo; rsp_word_o == $past(dv) && rsp_exc_o == 8'h00; endsequence
   property p_answer; tk |=> rsp_valid_o; endproperty
   property p_float_read; tk && fq |=> s_hi ##1 s_lo; endproperty
   property p_bad_func;
      tk && bf |=> rsp_exc_o == 8'h01 && rsp_last_o && rsp_word_o == 16'h0000; endproperty
   property p_mode_ok;
      wm && dv >= 16'h0001 && dv <= 16'h0006 |=> s_echo ##1 regulation_select_o == $past(dv, 2);
   endproperty
   property p_mode_bad; wm && (dv == 16'h0000 || dv > 16'h0006) |=> rsp_exc_o == 8'h03; endproperty
   property p_wave_bad; ws && req_addr_i == 16'h7010 && dv > 16'h0003 |=> rsp_exc_o == 8'h03;
   endproperty
   property p_onehot;
      $past(rst_b_i) |-> mode_onehot_o == 6'h01 << (regulation_select_o - 16'h0001); endproperty
   property p_source;
      $past(rst_b_i) && $past(ce_i) |->
         fg_drives_setpoint_o == ($past(set_point_source_i) == 16'h0001); endproperty
   property p_gate;
      sine_active_o == (fg_drives_setpoint_o && waveform_onehot_o[0])
      && square_active_o == (fg_drives_setpoint_o && waveform_onehot_o[1]); endproperty
   property p_sine_zero; !sine_active_o |-> sine_amplitude_o == 32'h0 && sine_offset_o == 32'h0
      && sine_period_o == 32'h0; endproperty
   property p_square_zero; !square_active_o |-> square_low_level_o == 32'h0
      && square_high_level_o == 32'h0; endproperty
   property p_period;
      sine_active_o |-> sine_period_o >= 32'h40000000 && sine_period_o <= 32'h477DE800; endproperty
   property p_level; square_active_o |-> square_high_level_o <= LEVEL_MAX; endproperty
   a_answer: assert property (p_answer) else $error("no answer after request");
   a_float_read: assert property (p_float_read) else $error("float read words wrong");
   a_bad_func: assert property (p_bad_func) else $error("bad function not refused");
   a_mode_ok: assert property (p_mode_ok) else $error("mode write not applied");
   a_mode_bad: assert property (p_mode_bad) else $error("bad mode not refused");
   a_wave_bad: assert property (p_wave_bad) else $error("bad waveform not refused");
   a_onehot: assert property (p_onehot) else $error("mode decode wrong");
   a_source: assert property (p_source) else $error("source flag wrong");
   a_gate: assert property (p_gate) else $error("waveform gating wrong");
   a_sine_zero: assert property (p_sine_zero) else $error("sine values leak");
   a_square_zero: assert property (p_square_zero) else $error("square values leak");
   a_period: assert property (p_period) else $error("period out of range");
   a_level: assert property (p_level) else $error("level above maximum");
endmodule // lmw_regs_checker
bind lmw_load_mode_waveform_regs lmw_regs_checker #(.LEVEL_MAX(LEVEL_MAX)) u_chk (
   .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .req_valid_i(req_valid_i),
   .req_func_i(req_func_i), .req_addr_i(req_addr_i), .req_count_i(req_count_i),
   .req_data_i(req_data_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
   .rsp_word_o(rsp_word_o), .rsp_last_o(rsp_last_o), .rsp_exc_o(rsp_exc_o),
   .set_point_source_i(set_point_source_i), .regulation_select_o(regulation_select_o),
   .mode_onehot_o(mode_onehot_o), .waveform_onehot_o(waveform_onehot_o),
   .fg_drives_setpoint_o(fg_drives_setpoint_o), .sine_active_o(sine_active_o),
   .square_active_o(square_active_o), .sine_amplitude_o(sine_amplitude_o),
   .sine_offset_o(sine_offset_o), .sine_period_o(sine_period_o),
   .square_low_level_o(square_low_level_o), .square_high_level_o(square_high_level_o));

/* lmw_host_model.sv */
// Remote host model issuing register read and write requests.
`timescale 1ns/10ps
module lmw_host_model (
   input  wire        sys_clk_i,
   input  wire        slow_i,
   output reg         req_valid_o,
   output reg  [7:0]  req_func_o,
   output reg  [15:0] req_addr_o,
   output reg  [15:0] req_count_o,
   output reg  [31:0] req_data_o,
   input  wire        req_ready_i,
   input  wire        rsp_valid_i,
   input  wire [15:0] rsp_word_i,
   input  wire        rsp_last_i,
   input  wire [7:0]  rsp_exc_i
);
   integer n;
   initial begin
      req_valid_o = 1'b0;
      req_func_o  = 8'h00;
      req_addr_o  = 16'h0000;
      req_count_o = 16'h0000;
      req_data_o  = 32'h00000000;
   end
   // Holds one request until taken, then gathers every answer word.
   task xfer(input [7:0] f, input [15:0] a, input [15:0] c, input [31:0] d,
             output [31:0] r, output [7:0] e, output ok);
      begin
         @(posedge sys_clk_i);
         if (slow_i) repeat (2) @(posedge sys_clk_i);
         #5;
         req_valid_o = 1'b1;
         req_func_o  = f;
         req_addr_o  = a;
         req_count_o = c;
         req_data_o  = d;
         n = 0;
         while (req_ready_i !== 1'b1 && n < 20) begin
            @(posedge sys_clk_i);
            #5;
            n = n + 1;
         end
         @(posedge sys_clk_i);
         #5;
         req_valid_o = 1'b0;
         req_addr_o  = ~a;
         req_data_o  = ~d;
         r  = {16'h0000, rsp_word_i};
         e  = rsp_exc_i;
         ok = rsp_valid_i === 1'b1 && n < 20;
         if (rsp_last_i !== 1'b1) begin
            @(posedge sys_clk_i);
            #5;
            r  = {r[15:0], rsp_word_i};
            ok = ok && rsp_valid_i === 1'b1 && rsp_last_i === 1'b1;
         end
      end
   endtask
endmodule // lmw_host_model

/* lmw_load_mode_waveform_regs_tb.sv */
// Self-checking testbench of the load mode and waveform register bank.
`timescale 1ns/10ps
module lmw_load_mode_waveform_regs_tb;
   localparam [31:0] LMAX = 32'h47000000;
   reg         sys_clk_i, rst_b_i, ce_i, slow;
   reg  [15:0] set_point_source_i;
   wire        req_valid_i, req_ready_o, rsp_valid_o, rsp_last_o;
   wire [7:0]  req_func_i, rsp_exc_o;
   wire [15:0] req_addr_i, req_count_i, rsp_word_o, regulation_select_o;
   wire [31:0] req_data_i, sine_amplitude_o, sine_offset_o, sine_period_o;
   wire [31:0] square_low_level_o, square_high_level_o;
   wire [5:0]  mode_onehot_o;
   wire [3:0]  waveform_onehot_o;
   wire        fg_drives_setpoint_o, sine_active_o, square_active_o;
   integer     error_cnt, cmp_count, i, seed;
   reg         g;
   reg  [2:0]  k;
   reg  [15:0] m, w, a;
   reg  [31:0] v;
   reg  [31:0] st [0:4];
   lmw_load_mode_waveform_regs #(.LEVEL_MAX(LMAX)) dut (
      .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .req_valid_i(req_valid_i),
      .req_func_i(req_func_i), .req_addr_i(req_addr_i), .req_count_i(req_count_i),
      .req_data_i(req_data_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
      .rsp_word_o(rsp_word_o), .rsp_last_o(rsp_last_o), .rsp_exc_o(rsp_exc_o),
      .set_point_source_i(set_point_source_i), .regulation_select_o(regulation_select_o),
      .mode_onehot_o(mode_onehot_o), .waveform_onehot_o(waveform_onehot_o),
      .fg_drives_setpoint_o(fg_drives_setpoint_o), .sine_active_o(sine_active_o),
      .square_active_o(square_active_o), .sine_amplitude_o(sine_amplitude_o),
      .sine_offset_o(sine_offset_o), .sine_period_o(sine_period_o),
      .square_low_level_o(square_low_level_o), .square_high_level_o(square_high_level_o));
   lmw_host_model u_host (
      .sys_clk_i(sys_clk_i), .slow_i(slow), .req_valid_o(req_valid_i),
      .req_func_o(req_func_i), .req_addr_o(req_addr_i), .req_count_o(req_count_i),
      .req_data_o(req_data_i), .req_ready_i(req_ready_o), .rsp_valid_i(rsp_valid_o),
      .rsp_word_i(rsp_word_o), .rsp_last_i(rsp_last_o), .rsp_exc_i(rsp_exc_o));
   initial begin
      sys_clk_i = 1'b0;
      forever #25 sys_clk_i = ~sys_clk_i;
   end
   task chk(input [31:0] got, input [31:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task req(input [7:0] f, input [15:0] ad, input [15:0] c, input [31:0] d,
            input [31:0] er, input [7:0] ee);
      reg [31:0] r;
      reg [7:0]  e;
      reg        ok;
      begin
         u_host.xfer(f, ad, c, d, r, e, ok);
         chk({31'h0, ok}, 32'h1);
         chk(r, er);
         chk({24'h0, e}, {24'h0, ee});
      end
   endtask
   task tick(input integer n);
      begin
         repeat (n) @(posedge sys_clk_i);
         #5;
      end
   endtask
   // Expected stored value of a float write after clamping.
   function [31:0] clamp(input [2:0] kk, input [31:0] x);
      begin
         if (kk == 3'h2)
            clamp = (x[31] || x < 32'h40000000) ? 32'h40000000 :
                    (x > 32'h477DE800 ? 32'h477DE800 : x);
         else
            clamp = x[31] ? 32'h00000000 : (x > LMAX ? LMAX : x);
      end
   endfunction
   task report_and_stop;
      begin
         $display("compares=%0d errors=%0d", cmp_count, error_cnt);
         if (error_cnt == 0 && cmp_count > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   initial begin
      #(50 * 20000);
      error_cnt = error_cnt + 1;
      report_and_stop;
   end
   initial begin
      error_cnt = 0;
      cmp_count = 0;
      seed = 32'hC249;
      rst_b_i = 1'b0;
      ce_i = 1'b1;
      slow = 1'b0;
      set_point_source_i = 16'h0000;
      m = 16'h0001;
      w = 16'h0000;
      tick(6);
      rst_b_i = 1'b1;
      req(8'h03, 16'h6040, 16'h0001, 32'h0, 32'h1, 8'h00);
      req(8'h03, 16'h7020, 16'h0001, 32'h0, 32'h0, 8'h00);
      req(8'h03, 16'h7080, 16'h0002, 32'h0, 32'h40000000, 8'h00);
      for (i = 0; i < 8; i = i + 1) begin
         g = i >= 1 && i <= 6;
         if (g) m = i[15:0];
         req(8'h06, 16'h6030, 16'h0001, i, g ? i : 0, g ? 8'h00 : 8'h03);
         req(8'h03, 16'h6040, 16'h0001, 32'h0, {16'h0, m}, 8'h00);
         chk({16'h0, regulation_select_o}, {16'h0, m});
         chk({26'h0, mode_onehot_o}, 32'h1 << (m - 16'h0001));
      end
      set_point_source_i = 16'h0001;
      for (i = 0; i < 5; i = i + 1) begin
         g = i < 4;
         if (g) w = i[15:0];
         req(8'h06, 16'h7010, 16'h0001, i, g ? i : 0, g ? 8'h00 : 8'h03);
         req(8'h03, 16'h7020, 16'h0001, 32'h0, {16'h0, w}, 8'h00);
         chk({28'h0, waveform_onehot_o}, 32'h1 << w);
         chk({30'h0, square_active_o, sine_active_o}, {30'h0, w == 1, w == 0});
      end
      for (i = 0; i < 30; i = i + 1) begin
         k = 3'(i % 5);
         a = 16'h7030 + {k, 5'h00};
         v = $random(seed);
         if (i % 2) v = (v >> 2) | 32'h40000000;
         st[k] = clamp(k, v);
         req(8'h10, a, 16'h0002, v, {16'h0, a}, 8'h00);
         req(8'h03, a + 16'h0010, 16'h0002, 32'h0, st[k], 8'h00);
      end
      req(8'h06, 16'h7010, 16'h0001, 32'h0, 32'h0, 8'h00);
      tick(2);
      chk(sine_amplitude_o, st[0]);
      chk(sine_offset_o, st[1]);
      chk(sine_period_o, st[2]);
      chk(square_low_level_o, 32'h0);
      req(8'h06, 16'h7010, 16'h0001, 32'h1, 32'h1, 8'h00);
      tick(2);
      chk(square_low_level_o, st[3]);
      chk(square_high_level_o, st[4]);
      chk(sine_amplitude_o, 32'h0);
      set_point_source_i = 16'h0002;
      tick(2);
      chk({31'h0, fg_drives_setpoint_o}, 32'h0);
      chk(square_high_level_o, 32'h0);
      ce_i = 1'b0;
      set_point_source_i = 16'h0001;
      tick(3);
      chk({31'h0, fg_drives_setpoint_o}, 32'h0);
      ce_i = 1'b1;
      tick(2);
      chk({31'h0, fg_drives_setpoint_o}, 32'h1);
      slow = 1'b1;
      req(8'h04, 16'h6030, 16'h0001, 32'h1, 32'h0, 8'h01);
      req(8'h06, 16'h7030, 16'h0001, 32'h1, 32'h0, 8'h02);
      req(8'h10, 16'h6030, 16'h0002, 32'h1, 32'h0, 8'h02);
      req(8'h03, 16'h6030, 16'h0001, 32'h0, 32'h0, 8'h02);
      req(8'h03, 16'h6050, 16'h0001, 32'h0, 32'h0, 8'h02);
      req(8'h03, 16'h7040, 16'h0001, 32'h0, 32'h0, 8'h03);
      req(8'h03, 16'h70C0, 16'h0002, 32'h0, st[4], 8'h00);
      rst_b_i = 1'b0;
      tick(2);
      rst_b_i = 1'b1;
      req(8'h03, 16'h6040, 16'h0001, 32'h0, 32'h1, 8'h00);
      report_and_stop;
   end
endmodule // lmw_load_mode_waveform_regs_tb
